// [spm_port.sv]
`timescale 1ns/10ps
`include "spm_consts.svh"
// What this block does
// - Data register write fills transmit buffer; read returns receive buffer.
// - Master: data write starts transfer, MSB first, incoming bits replace outgoing.
// - After last bit, shift register goes to receive buffer and interrupt raised.
// - Unread receive byte is overwritten by the next; no error flag.
// - Master never drives slave select; firmware uses any pin.
// - Master: buffered byte loads at once if idle, else after current byte.
// - Transmit-full high from write until byte loads; rewrite replaces pending byte.
// - Master emits exactly eight clock pulses per byte.
// - Master clock about one third active (away from idle level) at fastest rate, half otherwise.
// - Rate field bits 1:0 select 2, 1, 0.5, 0.0625 Mbit/s; ignored as slave.
// - Bit 3 sets clock idle level; bit 2 is phase.
// - Mode bits 5:4: 00 disabled (default), 01 master.
// - Slave: external clock and MOSI in, MISO out, only while select low.
// - Slave: buffered byte loads only when selected and idle; shifts on master edges.
// - Select released mid-byte aborts the byte with no interrupt.
// - Each select assertion reloads transmit buffer into the shift register.
// - Slave shifting needs no gated clock so it keeps running in suspend.
// - Done flag bit 7 set with interrupt at byte end; only firmware clears.
module spm_port
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        select_n_in,
  output logic             spi_irq
);
  import spm_pkg::*;

  localparam int R0 = `SPM_BIT_CYCLES(`SPM_RATE0_BPS);
  localparam int R1 = `SPM_BIT_CYCLES(`SPM_RATE1_BPS);
  localparam int R2 = `SPM_BIT_CYCLES(`SPM_RATE2_BPS);
  localparam int R3 = `SPM_BIT_CYCLES(`SPM_RATE3_BPS);

  // The fastest rate needs an active pulse of at least one cycle
  if (R0 < 3)
  begin : g_rate_check
    $error("Clock too slow for the fastest bit rate");
  end

  // Lead is spent at the idle level, trail is the active pulse
  function automatic logic [9:0] bit_len(input logic [1:0] r);
    case (r)
      2'd0:    bit_len = 10'(R0);
      2'd1:    bit_len = 10'(R1);
      2'd2:    bit_len = 10'(R2);
      default: bit_len = 10'(R3);
    endcase
  endfunction : bit_len

  function automatic logic [9:0] lead_len(input logic [1:0] r);
    if (r == 2'd0)
      lead_len = 10'(R0 - R0 / 3);
    else
      lead_len = bit_len(r) >> 1;
  endfunction : lead_len

  logic [7:0]    ctrl_reg;
  logic          done_reg;
  logic          txfull_reg;
  logic [7:0]    txbuf_reg;
  logic [7:0]    rxbuf_reg;
  logic [7:0]    shift_reg;
  logic [2:0]    bitcnt_reg;
  logic          active_reg;
  logic          irq_reg;
  spm_state_type state_reg;
  logic [9:0]    tick_reg;
  logic          sample_reg;
  logic          sck_reg;
  logic          mosi_reg;
  logic          miso_reg;
  logic          wr_pend_reg;
  logic          rd_pend_reg;
  logic [7:0]    addr_reg;
  logic [2:0]    sck_sync_reg;
  logic [2:0]    sel_sync_reg;
  logic [1:0]    mosi_sync_reg;
  logic [1:0]    miso_sync_reg;

  spm_mode_type mode;
  logic         idle_lvl;
  logic         phase;
  logic [1:0]   rate;
  assign mode     = spm_mode_type'(ctrl_reg[`SPM_BIT_MODE_HI:`SPM_BIT_MODE_LO]);
  assign idle_lvl = ctrl_reg[`SPM_BIT_IDLE_LVL];
  assign phase    = ctrl_reg[`SPM_BIT_PHASE];
  assign rate     = ctrl_reg[`SPM_BIT_RATE_HI:`SPM_BIT_RATE_LO];

  logic is_master;
  logic is_slave;
  assign is_master = (mode == SPM_MODE_MASTER);
  assign is_slave  = (mode == SPM_MODE_SLAVE);

  // AHB-Lite slave: zero wait states, always OKAY
  // One register per word: the decoded index is the byte address over four
  logic take;
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      addr_reg    <= haddr[9:2];
    end
  end

  logic wr_data;
  logic wr_ctrl;
  logic rd_data;
  assign wr_data = wr_pend_reg && (addr_reg == `SPM_OFF_DATA);
  assign wr_ctrl = wr_pend_reg && (addr_reg == `SPM_OFF_CTRL);
  assign rd_data = rd_pend_reg && (addr_reg == `SPM_OFF_DATA);

  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd_pend_reg)
    begin
      case (addr_reg)
        `SPM_OFF_DATA: hrdata = {24'h00_0000, rxbuf_reg};
        `SPM_OFF_CTRL: hrdata = {24'h00_0000, done_reg, txfull_reg, ctrl_reg[5:0]};
        `SPM_OFF_IRQ:  hrdata = {31'h0000_0000, irq_reg};
        default:       hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Pin synchronisers; only stage 1 onward is read by logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_sync_reg  <= 3'b000;
      sel_sync_reg  <= 3'b111;
      mosi_sync_reg <= 2'b00;
      miso_sync_reg <= 2'b00;
    end
    else
    begin
      sck_sync_reg  <= {sck_sync_reg[1:0], sck_in};
      sel_sync_reg  <= {sel_sync_reg[1:0], select_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
      miso_sync_reg <= {miso_sync_reg[0], miso_in};
    end
  end

  logic sel_active;
  logic sel_fall;
  logic sel_rise;
  logic sck_edge;
  logic sck_lead_edge;
  assign sel_active    = is_slave && !sel_sync_reg[1];
  assign sel_fall      = is_slave && sel_sync_reg[2] && !sel_sync_reg[1];
  assign sel_rise      = !sel_sync_reg[2] && sel_sync_reg[1];
  assign sck_edge      = sck_sync_reg[2] != sck_sync_reg[1];
  // Leading edge leaves the idle level
  assign sck_lead_edge = sck_edge && (sck_sync_reg[2] == idle_lvl);

  logic sin;
  assign sin = is_master ? miso_sync_reg[1] : mosi_sync_reg[1];

  // Master bit timer: LEAD is the first part, TRAIL the rest (a third at the fastest rate)
  logic m_edge1;
  logic m_edge2;
  logic m_load;
  assign m_edge1 = is_master && active_reg && (state_reg == SPM_LEAD) && (tick_reg == 10'd0);
  assign m_edge2 = is_master && active_reg && (state_reg == SPM_TRAIL) && (tick_reg == 10'd0);
  // A pending byte waits until the last trailing part has run out
  assign m_load  = is_master && !active_reg && txfull_reg && (state_reg != SPM_TRAIL);

  // Sample and change events, common to both modes
  logic ev_sample;
  logic ev_change;
  always_comb
  begin
    ev_sample = 1'b0;
    ev_change = 1'b0;
    if (is_master)
    begin
      ev_sample = phase ? m_edge2 : m_edge1;
      ev_change = phase ? m_edge1 : m_edge2;
    end
    else if (sel_active && active_reg && !sel_fall)
    begin
      ev_sample = sck_edge && (phase ? !sck_lead_edge : sck_lead_edge);
      ev_change = sck_edge && (phase ? sck_lead_edge : !sck_lead_edge);
    end
  end

  logic last_bit;
  logic byte_done;
  assign last_bit  = (bitcnt_reg == 3'd7);
  assign byte_done = ev_sample && last_bit;

  logic s_load;
  logic load;
  // Slave reload on select and idle-time load from buffer
  assign s_load = sel_fall || (sel_active && !active_reg && txfull_reg);
  assign load   = m_load || s_load;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= `SPM_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      txbuf_reg <= `SPM_DATA_RESET;
    else if (wr_data)
      txbuf_reg <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      txfull_reg <= 1'b0;
    else if (wr_data)
      txfull_reg <= 1'b1;
    else if (load)
      txfull_reg <= 1'b0;
  end

  // Firmware write clears; a completing byte in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      done_reg <= 1'b0;
    else if (byte_done)
      done_reg <= 1'b1;
    else if (wr_ctrl)
      done_reg <= hwdata[`SPM_BIT_DONE];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= byte_done;
  end
  assign spi_irq = irq_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rxbuf_reg <= `SPM_DATA_RESET;
    else if (byte_done)
      rxbuf_reg <= {shift_reg[6:0], sin};
  end

  // Shifter: no clock gating, so the slave path runs in suspend
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_reg  <= 8'h00;
      bitcnt_reg <= 3'd0;
      active_reg <= 1'b0;
      sample_reg <= 1'b0;
    end
    else if (!is_master && !sel_active)
    begin
      active_reg <= 1'b0;
      bitcnt_reg <= 3'd0;
    end
    else if (load)
    begin
      shift_reg  <= txbuf_reg;
      bitcnt_reg <= 3'd0;
      active_reg <= 1'b1;
    end
    else if (ev_sample)
    begin
      sample_reg <= sin;
      if (last_bit)
      begin
        active_reg <= 1'b0;
        shift_reg  <= {shift_reg[6:0], sin};
      end
      else
        bitcnt_reg <= bitcnt_reg + 3'd1;
    end
    // Phase 1 changes before any sample: that first change only presents the MSB
    else if (ev_change && (bitcnt_reg != 3'd0))
      shift_reg <= {shift_reg[6:0], sample_reg};
  end

  // Master clock generation: eight pulses, one per bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= SPM_IDLE;
      tick_reg  <= 10'd0;
      sck_reg   <= 1'b0;
    end
    // A phase 0 byte ends on a leading edge; its trailing part still runs out
    else if (!is_master || m_load || (!active_reg && (state_reg != SPM_TRAIL)))
    begin
      state_reg <= m_load ? SPM_LEAD : SPM_IDLE;
      tick_reg  <= lead_len(rate) - 10'd1;
      sck_reg   <= idle_lvl;
    end
    else if (tick_reg != 10'd0)
      tick_reg <= tick_reg - 10'd1;
    else if (state_reg == SPM_LEAD)
    begin
      state_reg <= SPM_TRAIL;
      sck_reg   <= !idle_lvl;
      tick_reg  <= bit_len(rate) - lead_len(rate) - 10'd1;
    end
    else
    begin
      state_reg <= SPM_LEAD;
      sck_reg   <= idle_lvl;
      tick_reg  <= lead_len(rate) - 10'd1;
    end
  end

  // Data out: MSB of the shifter, with phase 1 holding it through the first edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mosi_reg <= 1'b0;
      miso_reg <= 1'b0;
    end
    else
    begin
      mosi_reg <= is_master ? shift_reg[7] : 1'b0;
      miso_reg <= shift_reg[7];
    end
  end

  // Slave select is never driven by this block
  assign sck_out  = sck_reg;
  assign sck_oe   = is_master;
  assign mosi_out = mosi_reg;
  assign mosi_oe  = is_master;
  assign miso_out = miso_reg;
  assign miso_oe  = sel_active;

  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, hwdata[31:8], haddr[31:10], haddr[1:0], ctrl_reg[7:6], sel_rise};
endmodule : spm_port

// [spm_consts.svh]
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
// Register indices: one word each, the byte address is four times the index
`define SPM_OFF_DATA       8'h60
`define SPM_OFF_CTRL       8'h61
`define SPM_OFF_IRQ        8'h64
`define SPM_BIT_DONE       7
`define SPM_BIT_TXFULL     6
`define SPM_BIT_MODE_HI    5
`define SPM_BIT_MODE_LO    4
`define SPM_BIT_IDLE_LVL   3
`define SPM_BIT_PHASE      2
`define SPM_BIT_RATE_HI    1
`define SPM_BIT_RATE_LO    0
`define SPM_CTRL_RESET     8'h00
`define SPM_DATA_RESET     8'h00
`define SPM_CLK_HZ         20000000
`define SPM_RATE0_BPS      2000000
`define SPM_RATE1_BPS      1000000
`define SPM_RATE2_BPS      500000
`define SPM_RATE3_BPS      62500
`define SPM_BIT_CYCLES(r)  (`SPM_CLK_HZ / (r))
`define SPM_BITS_PER_BYTE  8
`endif

// [spm_pkg.sv]
package spm_pkg;
  typedef enum logic [1:0]
  {
    SPM_MODE_OFF,
    SPM_MODE_MASTER,
    SPM_MODE_SLAVE,
    SPM_MODE_RSVD
  } spm_mode_type;
  typedef enum logic [1:0]
  {
    SPM_IDLE,
    SPM_LEAD,
    SPM_TRAIL
  } spm_state_type;
endpackage : spm_pkg

// [spm_port_checker.sv]
`timescale 1ns/10ps
module spm_port_checker
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        select_n_in,
  input wire logic        spi_irq
);
  import spm_pkg::*;
  logic       wr_reg;
  logic [7:0] ctl_reg;
  logic [2:0] age_reg;
  logic [8:0] run_reg;
  logic [3:0] lead_reg;
  logic       act;
  logic       quiet;
  logic [1:0] mode;
  logic [8:0] half;
  assign act   = sck_out ^ ctl_reg[3];
  assign quiet = age_reg == 3'h7;
  assign mode  = ctl_reg[5:4];
  assign half  = ctl_reg[1] ? (ctl_reg[0] ? 9'h0a0 : 9'h014) : (ctl_reg[0] ? 9'h00a : 9'h003);
  // Mode or idle-level changes bend the clock for a few cycles, so checks wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_reg   <= 1'b0;
      ctl_reg  <= 8'h00;
      age_reg  <= 3'h0;
      run_reg  <= 9'h000;
      lead_reg <= 4'h0;
    end
    else
    begin
      wr_reg <= hsel && hready && htrans[1] && hwrite && haddr[9:2] == 8'h61;
      if (wr_reg)
        ctl_reg <= hwdata[7:0];
      if (wr_reg && hwdata[5:3] != ctl_reg[5:3])
        age_reg <= 3'h0;
      else if (!quiet)
        age_reg <= age_reg + 3'h1;
      run_reg <= act ? run_reg + 9'h001 : 9'h000;
      if (spi_irq)
        lead_reg <= 4'h0;
      else if (quiet && mode == SPM_MODE_MASTER && $rose(act))
        lead_reg <= lead_reg + 4'h1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_bus;
    hsel && hready && htrans[1] |=> hreadyout && !hresp && hrdata[31:8] == 24'h00_0000;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer wrong");
  property p_off;
    quiet && mode == SPM_MODE_OFF |-> !sck_oe && !mosi_oe && !miso_oe;
  endproperty
  a_off: assert property (p_off) else $error("driving while off");
  property p_rsvd;
    quiet && mode == SPM_MODE_RSVD |-> !sck_oe && !mosi_oe && !miso_oe;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("driving in mode 11");
  property p_master;
    quiet && mode == SPM_MODE_MASTER |-> sck_oe && mosi_oe && !miso_oe;
  endproperty
  a_master: assert property (p_master) else $error("master drive wrong");
  property p_duty;
    quiet && mode == SPM_MODE_MASTER && $fell(act) |-> run_reg == half;
  endproperty
  a_duty: assert property (p_duty) else $error("clock active time wrong");
  property p_eight;
    spi_irq && mode == SPM_MODE_MASTER |-> lead_reg + {3'h0, $rose(act)} == 4'h8;
  endproperty
  a_eight: assert property (p_eight) else $error("pulse count wrong");
  property p_irq;
    spi_irq |=> !spi_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq longer than a cycle");
  property p_sel;
    quiet && mode == SPM_MODE_SLAVE && $fell(select_n_in) |-> ##[1:4] miso_oe;
  endproperty
  a_sel: assert property (p_sel) else $error("slave output not enabled");
  property p_abort;
    quiet && mode == SPM_MODE_SLAVE && $rose(select_n_in) |-> !spi_irq [*6];
  endproperty
  a_abort: assert property (p_abort) else $error("irq after deselect");
endmodule : spm_port_checker
bind spm_port spm_port_checker spm_port_checker_i (.*);

// [spm_spi_dev.sv]
`timescale 1ns/10ps
module spm_spi_dev
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_sample_phase,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx
);
  logic [7:0] sh_reg;
  initial
  begin
    miso = 1'b0;
    rx = 8'h00;
    sh_reg = 8'h00;
  end
  always @(negedge sel_n)
  begin
    sh_reg = tx;
    miso = tx[7];
  end
  // A released line shows the inverse, so stale data cannot pass
  always @(posedge sel_n)
    miso = ~miso;
  // Each frame inverts the byte, so back-to-back frames differ
  always @(sck)
  begin
    if (!sel_n && (sck ^ clock_idle_level ^ clock_sample_phase))
      rx = {rx[6:0], mosi};
    else if (!sel_n)
    begin
      if (clock_sample_phase)
        miso = sh_reg[7];
      sh_reg = {sh_reg[6:0], ~sh_reg[7]};
      if (!clock_sample_phase)
        miso = sh_reg[7];
    end
  end
endmodule : spm_spi_dev

// [tb_spm_port.sv]
`timescale 1ns/10ps
`include "spm_consts.svh"
module tb_spm_port;
  import spm_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hreadyout, hresp, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, spi_irq;
  logic [31:0] hrdata;
  logic        sck_in = 1'b0;
  logic        mosi_in = 1'b0;
  logic        miso_in;
  logic        select_n_in = 1'b1;
  logic        dev_sel_n = 1'b1;
  logic        sck_q = 1'b0;
  logic [7:0]  ctl = 8'h00;
  logic [7:0]  dev_tx = 8'h00;
  logic [7:0]  dev_rx, q, got;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          pulses, irqs = 0;
  time         t0, tl;
  // Rows: control, byte sent, byte the far side answers with
  logic [7:0]  rows [4][3] = '{'{8'h10, 8'ha5, 8'h5a}, '{8'h15, 8'h81, 8'h7e},
                               '{8'h1a, 8'h3c, 8'hc3}, '{8'h1f, 8'h01, 8'h80}};
  int          per [4] = '{1, 2, 4, 32};
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  spm_port spm_port_i (.*);
  spm_spi_dev spm_spi_dev_i (.sck(sck_out), .mosi(mosi_out), .sel_n(dev_sel_n), .clock_idle_level(ctl[3]),
                             .clock_sample_phase(ctl[2]), .tx(dev_tx), .miso(miso_in), .rx(dev_rx));
  always @(negedge hclk)
  begin
    sck_q <= sck_out;
    if (sck_out !== sck_q && sck_out !== ctl[3])
    begin
      if (pulses == 0)
        t0 = $time;
      tl = $time;
      pulses++;
    end
    if (spi_irq === 1'b1)
      irqs++;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h00_0000, a, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata[7:0];
  endtask : bus
  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      bus(1'b0, 8'h61, 8'h00);
      n++;
    end
    while (q[7] !== 1'b1 && n < 3000);
    chk({7'h00, q[7]}, 8'h01);
  endtask : wait_done
  task automatic sbyte(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      mosi_in <= d[7 - i];
      repeat (4) @(posedge hclk);
      sck_in <= 1'b1;
      // Slave output moves four cycles after the falling edge; read it well clear
      repeat (2) @(posedge hclk);
      got = {got[6:0], miso_out};
      repeat (2) @(posedge hclk);
      sck_in <= 1'b0;
    end
    mosi_in <= ~mosi_in;
    repeat (8) @(posedge hclk);
  endtask : sbyte
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial
  begin
    #2_000_000;
    fail_count++;
    results;
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[r])
    begin
      ctl <= rows[r][0];
      dev_tx <= rows[r][2];
      bus(1'b1, 8'h61, rows[r][0]);
      // Let the clock reach its new idle level before the far side is selected
      repeat (2) @(posedge hclk);
      dev_sel_n <= 1'b0;
      pulses = 0;
      bus(1'b1, 8'h60, rows[r][1]);
      wait_done;
      repeat (400) @(posedge hclk);
      chk(8'(pulses), 8'h08);
      chk(8'((tl - t0) / 500), 8'(7 * per[r]));
      chk({7'h00, sck_out}, {7'h00, ctl[3]});
      bus(1'b0, 8'h61, 8'h00);
      chk(q, rows[r][0] | 8'h80);
      bus(1'b0, 8'h60, 8'h00);
      chk(q, rows[r][2]);
      chk(dev_rx, rows[r][1]);
      dev_sel_n <= 1'b1;
    end
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h60, 8'h00);
    chk(q, `SPM_DATA_RESET);
    bus(1'b0, 8'h61, 8'h00);
    chk(q, `SPM_CTRL_RESET);
    bus(1'b1, 8'h70, 8'hff);
    bus(1'b0, 8'h70, 8'h00);
    chk(q, 8'h00);
    ctl <= 8'h10;
    dev_tx <= 8'h69;
    bus(1'b1, 8'h61, 8'h10);
    dev_sel_n <= 1'b0;
    bus(1'b1, 8'h60, 8'h11);
    bus(1'b1, 8'h60, 8'h22);
    bus(1'b1, 8'h60, 8'h33);
    bus(1'b0, 8'h61, 8'h00);
    chk(q & 8'h40, 8'h40);
    wait_done;
    chk(dev_rx, 8'h11);
    bus(1'b1, 8'h61, 8'h10);
    wait_done;
    repeat (20) @(posedge hclk);
    chk(dev_rx, 8'h33);
    bus(1'b0, 8'h60, 8'h00);
    chk(q, 8'h96);
    dev_sel_n <= 1'b1;
    bus(1'b1, 8'h61, 8'h30);
    repeat (10) @(posedge hclk);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
    bus(1'b1, 8'h61, 8'h20);
    bus(1'b1, 8'h60, 8'ha5);
    bus(1'b0, 8'h61, 8'h00);
    chk(q, 8'h60);
    select_n_in <= 1'b0;
    repeat (8) @(posedge hclk);
    sbyte(8'h3c, 8);
    chk(got, 8'ha5);
    bus(1'b0, 8'h60, 8'h00);
    chk(q, 8'h3c);
    select_n_in <= 1'b1;
    bus(1'b1, 8'h61, 8'h20);
    bus(1'b1, 8'h60, 8'h96);
    select_n_in <= 1'b0;
    repeat (8) @(posedge hclk);
    sbyte(8'hff, 4);
    select_n_in <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(1'b0, 8'h61, 8'h00);
    chk(q, 8'h20);
    select_n_in <= 1'b0;
    repeat (8) @(posedge hclk);
    sbyte(8'h0f, 8);
    chk(got, 8'h96);
    chk(8'(irqs), 8'h08);
    results;
  end
endmodule : tb_spm_port
